// ==== hdl/sbr_pkg.sv ====
// Package of constants for the shared-bus ready output block
// Contract
// - By default the output pin is weakly pulled toward the supply when chip select is high.
// - With the pull-up enable cleared to 0 the output pin floats when chip select is high.
// - While chip select is high no data-ready pulse ever appears on the output pin.
// - When chip select falls the pin is driven high or low three system clocks later, with no serial clock needed.
// - A low pin while chip select is low means an unread result is waiting to be shifted out.
// - A high pin means no new result, and a read returns the previously read result again.
// - A result read at any moment is whole and consistent, never torn by a result update.
// - Transfers use clock polarity 0 and phase 1, changing on rising and sampling on falling edges.
// - The pull-up enable is bit 3 of the configuration word and resets to 1.
// - A transfer is abandoned when the serial clock stays low longer than 28 ms.
package sbr_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h10;
    localparam int CFG_PULLUP_BIT = 3;
    localparam int CFG_NOP_LSB = 1;
    localparam logic [1:0] CFG_NOP_VALID = 2'h1;
    localparam logic PULLUP_RST = 1'h1;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam int CLK_MHZ = 250;
    localparam int TIMEOUT_MS = 28;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int TMO_W = 23;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_ABORT
    } sbr_state_t;
endpackage

// ==== hdl/sbr_sync.sv ====
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ns
module sbr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Lanes
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    ////////////////////////////////////////////////////////////////
    // First stage is read only by the second
    always_comb begin
        nxt_meta = asyncIn;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign syncOut = sync_ff;
endmodule

// ==== hdl/sbr_shared_bus_ready.sv ====
// Output pin and data-ready logic of a serial converter on a shared bus
`timescale 1ns/1ns
module sbr_shared_bus_ready #(
    parameter int TIMEOUT_CYCLES = sbr_pkg::TIMEOUT_CYCLES
) (
    // System clock and reset
    input wire logic clock,
    input wire logic srst,
    // Conversion results from the converter core
    input wire logic resultValid,
    input wire logic [15:0] resultData,
    // Serial link pins
    input wire logic sclkPin,
    input wire logic csPinN,
    input wire logic dinPin,
    output logic serialOutReadyPin,
    output logic serialOutReadyPinOe,
    output logic pullUpActive,
    // Status
    output logic pullUpEnable,
    output logic newResult
);
    ////////////////////////////////////////////////////////////////
    // Pin synchronisers into the system domain
    logic [2:0] syncIn;
    logic [2:0] syncOut;
    logic csLowSync;
    logic sclkSync;
    logic frameDoneSync;
    logic frameDone_ff;

    // Frame done crosses back as a level, held until chip select rises or the link aborts
    assign syncIn = {frameDone_ff, sclkPin, ~csPinN};

    sbr_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .asyncIn(syncIn),
        .syncOut(syncOut)
    );

    assign csLowSync = syncOut[0];
    assign sclkSync = syncOut[1];
    assign frameDoneSync = syncOut[2];

    ////////////////////////////////////////////////////////////////
    // Frame control state in the system domain
    sbr_pkg::sbr_state_t state_ff;
    sbr_pkg::sbr_state_t nxt_state;
    logic [sbr_pkg::TMO_W-1:0] lowCnt_ff;
    logic [sbr_pkg::TMO_W-1:0] nxt_lowCnt;
    logic abort_ff;
    logic nxt_abort;
    logic doneSeen_ff;
    logic nxt_doneSeen;
    logic driveOn_ff;
    logic nxt_driveOn;
    logic frameDoneEvt;
    logic timedOut;

    assign frameDoneEvt = frameDoneSync & ~doneSeen_ff;
    // Timeout counted on the system clock, as the link clock may stop dead
    assign timedOut = (lowCnt_ff >= sbr_pkg::TMO_W'(TIMEOUT_CYCLES - 1));

    always_comb begin
        nxt_state = state_ff;
        nxt_lowCnt = lowCnt_ff;
        nxt_abort = abort_ff;
        nxt_doneSeen = frameDoneSync;
        // Three clocks behind the pin, traded for a clean synchronised path
        nxt_driveOn = csLowSync;
        case (state_ff)
            sbr_pkg::ST_IDLE: begin
                nxt_lowCnt = '0;
                nxt_abort = 1'b0;
                if (csLowSync) begin
                    nxt_state = sbr_pkg::ST_FRAME;
                end
            end
            sbr_pkg::ST_FRAME: begin
                if (!csLowSync) begin
                    nxt_state = sbr_pkg::ST_IDLE;
                end else if (sclkSync) begin
                    nxt_lowCnt = '0;
                end else if (timedOut) begin
                    nxt_state = sbr_pkg::ST_ABORT;
                    nxt_abort = 1'b1;
                end else begin
                    nxt_lowCnt = lowCnt_ff + 1'b1;
                end
            end
            sbr_pkg::ST_ABORT: begin
                // Held until chip select rises so the link stays cleared
                nxt_lowCnt = '0;
                if (!csLowSync) begin
                    nxt_state = sbr_pkg::ST_IDLE;
                    nxt_abort = 1'b0;
                end
            end
            default: begin
                nxt_state = sbr_pkg::ST_IDLE;
                nxt_lowCnt = '0;
                nxt_abort = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= sbr_pkg::ST_IDLE;
            lowCnt_ff <= '0;
            abort_ff <= 1'b0;
            doneSeen_ff <= 1'b0;
            driveOn_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            lowCnt_ff <= nxt_lowCnt;
            abort_ff <= nxt_abort;
            doneSeen_ff <= nxt_doneSeen;
            driveOn_ff <= nxt_driveOn;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Result holding and the new-result flag
    logic [15:0] latest_ff;
    logic [15:0] nxt_latest;
    logic [15:0] snap_ff;
    logic [15:0] nxt_snap;
    logic newFlag_ff;
    logic nxt_newFlag;
    logic inFlight_ff;
    logic nxt_inFlight;
    logic readyBit_ff;
    logic nxt_readyBit;
    logic frameStart;

    // Seen only in idle, so a held select counts as one frame
    assign frameStart = (state_ff == sbr_pkg::ST_IDLE) && csLowSync;

    always_comb begin
        nxt_latest = latest_ff;
        nxt_snap = snap_ff;
        nxt_newFlag = newFlag_ff;
        nxt_inFlight = inFlight_ff;
        nxt_readyBit = readyBit_ff;
        if (frameStart) begin
            // Snapshot frozen for the frame so updates cannot tear a read
            if (newFlag_ff) begin
                nxt_snap = latest_ff;
            end
            nxt_inFlight = newFlag_ff;
            nxt_readyBit = ~newFlag_ff;
        end
        if (frameDoneEvt && inFlight_ff) begin
            nxt_newFlag = 1'b0;
            nxt_inFlight = 1'b0;
        end
        if (state_ff == sbr_pkg::ST_IDLE && !csLowSync) begin
            nxt_inFlight = 1'b0;
        end
        // Set wins over the clear from a finished read
        if (resultValid) begin
            nxt_latest = resultData;
            nxt_newFlag = 1'b1;
            nxt_inFlight = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            latest_ff <= sbr_pkg::RESULT_RST;
            snap_ff <= sbr_pkg::RESULT_RST;
            newFlag_ff <= 1'b0;
            inFlight_ff <= 1'b0;
            readyBit_ff <= 1'b1;
        end else begin
            latest_ff <= nxt_latest;
            snap_ff <= nxt_snap;
            newFlag_ff <= nxt_newFlag;
            inFlight_ff <= nxt_inFlight;
            readyBit_ff <= nxt_readyBit;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Configuration taken from a completed frame
    logic pullUpEn_ff;
    logic nxt_pullUpEn;
    logic [15:0] cfgWord_ff;

    // Only the one valid code may touch the configuration
    function automatic logic cfgAccepted(input logic [15:0] word);
        return word[sbr_pkg::CFG_NOP_LSB +: 2] == sbr_pkg::CFG_NOP_VALID;
    endfunction

    always_comb begin
        nxt_pullUpEn = pullUpEn_ff;
        // Word is quasi-static here: link shifting stops after the last bit
        if (frameDoneEvt && cfgAccepted(cfgWord_ff)) begin
            nxt_pullUpEn = cfgWord_ff[sbr_pkg::CFG_PULLUP_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pullUpEn_ff <= sbr_pkg::PULLUP_RST;
        end else begin
            pullUpEn_ff <= nxt_pullUpEn;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link domain; all but the received word cleared while chip select is high or on abort
    logic linkRst;
    logic started_ff;
    logic nxt_started;
    logic outBit_ff;
    logic nxt_outBit;
    logic [15:0] shOut_ff;
    logic [15:0] nxt_shOut;
    logic [sbr_pkg::CNT_W-1:0] bitCnt_ff;
    logic [sbr_pkg::CNT_W-1:0] nxt_bitCnt;
    logic [15:0] nxt_cfgWord;
    logic nxt_frameDone;

    // Shared shift step, MSB first
    function automatic logic [15:0] shiftIn(input logic [15:0] word, input logic bitIn);
        return {word[14:0], bitIn};
    endfunction

    assign linkRst = csPinN | abort_ff;

    // Rising edges launch data; snapshot is stable since frame start
    always_comb begin
        nxt_started = 1'b1;
        nxt_outBit = outBit_ff;
        nxt_shOut = shOut_ff;
        if (!started_ff) begin
            nxt_outBit = snap_ff[15];
            nxt_shOut = shiftIn(snap_ff, 1'b1);
        end else begin
            nxt_outBit = shOut_ff[15];
            nxt_shOut = shiftIn(shOut_ff, 1'b1);
        end
    end

    always_ff @(posedge sclkPin or posedge linkRst) begin
        if (linkRst) begin
            started_ff <= 1'b0;
            outBit_ff <= 1'b1;
            shOut_ff <= 16'hffff;
        end else begin
            started_ff <= nxt_started;
            outBit_ff <= nxt_outBit;
            shOut_ff <= nxt_shOut;
        end
    end

    // Falling edges sample the incoming word
    always_comb begin
        nxt_bitCnt = bitCnt_ff;
        nxt_cfgWord = cfgWord_ff;
        nxt_frameDone = frameDone_ff;
        if (bitCnt_ff < sbr_pkg::FRAME_LAST) begin
            nxt_cfgWord = shiftIn(cfgWord_ff, dinPin);
            nxt_bitCnt = bitCnt_ff + 1'b1;
            if (bitCnt_ff == sbr_pkg::FRAME_LAST - 1'b1) begin
                nxt_frameDone = 1'b1;
            end
        end
    end

    always_ff @(negedge sclkPin or posedge linkRst) begin
        if (linkRst) begin
            bitCnt_ff <= '0;
            frameDone_ff <= 1'b0;
        end else begin
            bitCnt_ff <= nxt_bitCnt;
            frameDone_ff <= nxt_frameDone;
        end
    end

    // No clear on select: the system side may pick the word up after chip select rises
    always_ff @(negedge sclkPin) begin
        cfgWord_ff <= nxt_cfgWord;
    end

    ////////////////////////////////////////////////////////////////
    // Pin drive
    // Ready level until the first rising edge, then the shifted data
    assign serialOutReadyPin = started_ff ? outBit_ff : readyBit_ff;
    // Driver off whenever chip select is high: no pulse can escape
    assign serialOutReadyPinOe = driveOn_ff & ~csPinN;
    // Pull-up only matters while the driver is off
    assign pullUpActive = ~serialOutReadyPinOe & pullUpEn_ff;
    // Status straight from the registers
    assign pullUpEnable = pullUpEn_ff;
    assign newResult = newFlag_ff;
endmodule

// ==== dv/sbr_master.sv ====
// Serial master model polling one converter
`timescale 1ns/1ns
module sbr_master (
    // System clock
    input wire logic clock,
    // Bus lines
    output logic sclkPin,
    output logic csPinN,
    output logic dinPin,
    input wire logic busLine
);
    initial begin
        sclkPin = 1'h0;
        csPinN = 1'h1;
        dinPin = 1'h0;
    end
    ////////////////////////
    // Own select per device; clock only moves inside a frame
    task automatic frame(input logic [15:0] tx, input int nb, input int hold,
        output logic rdy, output logic [15:0] rx);
        @(posedge clock);
        #1 csPinN = 1'h0;
        #20 rdy = busLine;
        rx = 16'h0000;
        for (int i = 15; i >= 16 - nb; i--) begin
            sclkPin = 1'h1;
            dinPin = tx[i];
            #6 sclkPin = 1'h0;
            rx[i] = busLine;
            #6;
        end
        #(hold) csPinN = 1'h1;
        dinPin = ~dinPin;
        #20;
    endtask
endmodule

// ==== dv/sbr_shared_bus_ready_properties.sv ====
// Checker of pin and ready behaviour at the block ports
`timescale 1ns/1ns
module sbr_shared_bus_ready_properties #(
    parameter int TIMEOUT_CYCLES = 200
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Watched ports
    input wire logic resultValid,
    input wire logic [15:0] resultData,
    input wire logic sclkPin,
    input wire logic csPinN,
    input wire logic dinPin,
    input wire logic serialOutReadyPin,
    input wire logic serialOutReadyPinOe,
    input wire logic pullUpActive,
    input wire logic pullUpEnable,
    input wire logic newResult
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    ////////////////////////
    // One spare cycle, as the pull indication may be registered
    sequence s_csHigh2;
        csPinN[*2] ##0 $stable(pullUpEnable);
    endsequence
    sequence s_csLow4;
        $fell(csPinN) ##0 (!csPinN)[*4];
    endsequence
    property p_float;
        s_csHigh2 ##0 !pullUpEnable |-> !pullUpActive && !serialOutReadyPinOe;
    endproperty
    a_float: assert property (p_float) else $error("pin not floating");
    property p_pull;
        s_csHigh2 ##0 pullUpEnable |-> pullUpActive && !serialOutReadyPinOe;
    endproperty
    a_pull: assert property (p_pull) else $error("pin not pulled up");
    property p_noPulse;
        csPinN |-> !serialOutReadyPinOe;
    endproperty
    a_noPulse: assert property (p_noPulse) else $error("pin driven while deselected");
    property p_drive;
        s_csLow4 |-> serialOutReadyPinOe;
    endproperty
    a_drive: assert property (p_drive) else $error("pin not driven after select");
    property p_rdy;
        $rose(serialOutReadyPinOe) |-> serialOutReadyPin == !$past(newResult);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready level wrong");
    property p_setFlag;
        resultValid |=> newResult;
    endproperty
    a_setFlag: assert property (p_setFlag) else $error("flag not set");
    property p_hold;
        (!serialOutReadyPinOe)[*8] ##0 newResult && !resultValid |=> newResult;
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost while idle");
    property p_rst;
        disable iff (1'h0) srst |=> pullUpEnable && !newResult && !serialOutReadyPinOe;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
////////////////////////
bind sbr_shared_bus_ready sbr_shared_bus_ready_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_p (
    .clock(clock), .srst(srst), .resultValid(resultValid), .resultData(resultData),
    .sclkPin(sclkPin), .csPinN(csPinN), .dinPin(dinPin), .serialOutReadyPin(serialOutReadyPin),
    .serialOutReadyPinOe(serialOutReadyPinOe), .pullUpActive(pullUpActive),
    .pullUpEnable(pullUpEnable), .newResult(newResult));

// ==== dv/tb_top.sv ====
// Testbench of the shared-bus ready output block
`timescale 1ns/1ns
module tb_top;
    localparam int TMO = 200;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic resultValid = 1'h0;
    logic [15:0] resultData = 16'h0000;
    logic sclkPin, csPinN, dinPin, pin, oe, pullUpActive, pullUpEnable, newResult, busLine, rdy;
    logic toggle = 1'h0;
    logic pend = 1'h0;
    logic [15:0] rx;
    logic [15:0] cur = 16'h0000;
    logic [15:0] last = 16'h0000;
    int nRes = 0;
    int err_total = 0;
    int total_checks = 0;
    always #2 clock = ~clock;
    always @(posedge clock) toggle <= ~toggle;
    // Floating line keeps changing so a stale value never matches
    assign busLine = oe ? pin : (pullUpActive ? 1'h1 : toggle);
    sbr_shared_bus_ready #(.TIMEOUT_CYCLES(TMO)) i_dut (.clock(clock), .srst(srst),
        .resultValid(resultValid), .resultData(resultData), .sclkPin(sclkPin),
        .csPinN(csPinN), .dinPin(dinPin), .serialOutReadyPin(pin), .serialOutReadyPinOe(oe),
        .pullUpActive(pullUpActive), .pullUpEnable(pullUpEnable), .newResult(newResult));
    sbr_master i_mst (.clock(clock), .sclkPin(sclkPin), .csPinN(csPinN), .dinPin(dinPin),
        .busLine(busLine));
    ////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [15:0] cfgWord(input logic pu, input logic [1:0] code);
        return {12'h000, pu, code, 1'h1};
    endfunction
    task automatic post(input logic [15:0] d);
        @(posedge clock);
        #1 resultValid = 1'h1;
        resultData = d;
        cur = d;
        pend = 1'h1;
        nRes++;
        @(posedge clock);
        #1 resultValid = 1'h0;
        resultData = ~d;
    endtask
    // Expectation frozen at frame start
    task automatic rd(input logic [15:0] tx, input int nb, input int hold);
        logic p0 = pend;
        logic [15:0] c0 = cur;
        int n0 = nRes;
        i_mst.frame(tx, nb, hold, rdy, rx);
        check("ready", {15'h0, !p0}, {15'h0, rdy});
        if (nb == 16) begin
            check("data", p0 ? c0 : last, rx);
            last = p0 ? c0 : last;
            if (p0 && nRes == n0) pend = 1'h0;
        end
        check("flag", {15'h0, pend}, {15'h0, newResult});
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        print_verdict();
    end
    initial begin
        void'($urandom(74973));
        repeat (16) @(posedge clock);
        #1 srst = 1'h0;
        repeat (4) @(posedge clock);
        check("pullUp", 16'h3, {14'h0, pullUpEnable, pullUpActive});
        rd(16'h0000, 16, 6);
        for (int i = 0; i < 6; i++) begin
            post(i == 0 ? 16'hffff : i == 1 ? 16'h0000 : 16'($urandom));
            rd(cfgWord(2'(i) == 2'h1, 2'(i)), 16, 6);
            rd(16'h0000, 16, 6);
            check("pullEn", 16'h1, {15'h0, pullUpEnable});
        end
        $display("test codes done");
        post(16'($urandom));
        post(16'($urandom));
        rd(16'h0000, 16, 6);
        post(16'($urandom));
        fork
            rd(16'h0000, 16, 6);
            begin
                #100;
                post(16'($urandom));
            end
        join
        rd(16'h0000, 16, 6);
        $display("test results done");
        post(16'($urandom));
        rd(16'h0000, 8, 6);
        rd(16'h0000, 4, TMO * 4 + 100);
        rd(16'h0000, 16, 6);
        $display("test abort done");
        rd(cfgWord(1'h0, 2'h1), 16, 6);
        check("float", 16'h0, {13'h0, pullUpEnable, pullUpActive, oe});
        rd(cfgWord(1'h1, 2'h1), 16, 6);
        check("pull", 16'h6, {13'h0, pullUpEnable, pullUpActive, oe});
        $display("test config done");
        print_verdict();
    end
endmodule
